// file: core/adc_link_params.svh
`ifndef ADC_LINK_PARAMS_SVH
`define ADC_LINK_PARAMS_SVH

// ****************************************
// control byte layout
// ****************************************
`define CB_START        7
`define CB_SEL_HI       6
`define CB_SEL_MID      5
`define CB_SEL_LO       4
`define CB_POLARITY     3
`define CB_INPUT_CFG    2
`define CB_PC_HI        1
`define CB_PC_LO        0
`define CB_BITS         4'h8
`define TRACK_BIT       4'h5
`define CONV_SCLKS      4'hF
`define RESULT_BITS     10
`define COM_CODE        4'h8
`define FRAME_SCLKS     5'h18
`define RES_MSB_POS     14
`define RES_LSB_POS     5

// ****************************************
// timing
// ****************************************
`define CLK_NS          20
`define T_ACQ_MIN_NS    1500
`define ACQ_SCLKS       3
`define SCLK_HALF_CYC   ((`T_ACQ_MIN_NS + 2 * `ACQ_SCLKS * `CLK_NS - 1) / (2 * `ACQ_SCLKS * `CLK_NS))
`define T_CONV_INT_NS   7500
`define CONV_INT_CYC    (`T_CONV_INT_NS / `CLK_NS)
`define CONV_CNT_W      16

// ****************************************
// controller registers
// ****************************************
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_MASK        4'h8
`define REG_RESULT      4'hC
`define EV_DONE         0
`define EV_REJECT       1
`define ST_BUSY         2

`endif

// file: core/adc_link_pkg.sv
package adc_link_pkg;
  `include "adc_link_params.svh"

  typedef enum logic [1:0] {
    PH_HUNT = 2'b00,
    PH_CTRL = 2'b01,
    PH_SKIP = 2'b10
  } in_phase_t;

  typedef enum logic [1:0] {
    OS_IDLE  = 2'b00,
    OS_MSB   = 2'b01,
    OS_CONV  = 2'b10,
    OS_SHIFT = 2'b11
  } out_phase_t;

  typedef enum logic [1:0] {
    PC_FULL_PD = 2'b00,
    PC_FAST_PD = 2'b01,
    PC_INT_CLK = 2'b10,
    PC_EXT_CLK = 2'b11
  } power_clock_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RUN  = 2'b01,
    H_WAIT = 2'b10,
    H_TAIL = 2'b11
  } host_phase_t;

  typedef struct packed {
    logic [1:0]             cs_sync;
    logic [2:0]             ck_sync;
    logic [1:0]             di_sync;
    in_phase_t              in_ph;
    logic [3:0]             bit_cnt;
    logic [7:0]             ctrl;
    out_phase_t             out_ph;
    logic [3:0]             out_cnt;
    logic [`RESULT_BITS-1:0] res;
    logic [`CONV_CNT_W-1:0] conv_cnt;
    power_clock_t           pc;
    logic [2:0]             pos_ch;
    logic [3:0]             neg_ch;
    logic                   unipolar;
    logic                   dout;
    logic                   strb;
    logic                   track;
    logic                   taken;
    logic                   powered_down;
  } dev_state_t;

  typedef struct packed {
    logic                   aw_hold;
    logic [3:0]             aw_addr;
    logic                   w_hold;
    logic [31:0]            w_data;
    logic                   w_lane0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [7:0]             ctrl_byte;
    logic [1:0]             status;
    logic [1:0]             mask;
    logic [`RESULT_BITS-1:0] result;
    host_phase_t            ph;
    logic [7:0]             div;
    logic [4:0]             bit_cnt;
    logic [7:0]             tx;
    logic [23:0]            rx;
    logic [1:0]             do_sync;
    logic [1:0]             st_sync;
    logic                   saw_low;
    logic                   sclk;
    logic                   cs_n;
    logic                   din;
  } host_state_t;
endpackage : adc_link_pkg

// file: core/adc_link_if.sv
`timescale 1ns/1ns
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic strb_o;
  logic strb_oe;
  logic dout;
  logic strb;

  // released pins read low, as if pulled down
  assign dout = dout_oe ? dout_o : 1'b0;
  assign strb = strb_oe ? strb_o : 1'b0;

  modport device (input sclk, input cs_n, input din,
                  output dout_o, output dout_oe, output strb_o, output strb_oe);
  modport host   (output sclk, output cs_n, output din, input dout, input strb);
endinterface : adc_link_if

// file: core/adc_serial_device.sv
`timescale 1ns/1ns
// Operation
// - zeros ignored until start bit arrives
// - first one is control byte MSB
// - one din bit per sclk rise
// - control byte fields decoded by position
// - single-ended channel map, negative is common
// - host sends control byte per conversion
// - all-ones byte converts channel seven externally
// - external mode strobe high one period before MSB
// - fifteen sclk cycles per conversion
// - outputs change only on sclk falls, except the internal mode strobe rise at conversion end
// - host uses clock polarity/phase zero
// - host uses three byte transfers
// - host keeps acquisition at least 1.5us
// - differential pairs, bit six picks polarity
// - internal mode strobe low while converting
// - track after fifth bit, hold after eighth
// - dout released while chip select high
module adc_serial_device
  import adc_link_pkg::*;
#(
  parameter int CONV_CYCLES_INT = `CONV_INT_CYC
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  adc_link_if.device                   link,
  input  wire logic [`RESULT_BITS-1:0] sample_data,
  output      logic                    sample_taken,
  output      logic                    tracking,
  output      logic [2:0]              pos_channel,
  output      logic [3:0]              neg_channel,
  output      logic                    unipolar,
  output      logic [1:0]              power_clock_mode,
  output      logic                    powered_down
);

  localparam logic [`CONV_CNT_W-1:0] CONV_LAST = `CONV_CNT_W'(CONV_CYCLES_INT - 1);

  dev_state_t r_r;
  dev_state_t r_nxt;

  logic cs_high;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;

  // ****************************************
  // channel decode
  // ****************************************
  function automatic logic [6:0] decode_channels(input logic [7:0] cb);
    logic [2:0] pos;
    logic [3:0] neg;
    pos = 3'h0;
    neg = `COM_CODE;
    if (cb[`CB_INPUT_CFG]) begin
      pos = {cb[`CB_SEL_MID], cb[`CB_SEL_LO], cb[`CB_SEL_HI]};
      neg = `COM_CODE;
    end else begin
      pos = {cb[`CB_SEL_MID], cb[`CB_SEL_LO], cb[`CB_SEL_HI]};
      neg = {1'b0, cb[`CB_SEL_MID], cb[`CB_SEL_LO], ~cb[`CB_SEL_HI]};
    end
    decode_channels = {pos, neg};
  endfunction : decode_channels

  // ****************************************
  // pin sampling
  // ****************************************
  // logic reads only the second stage; the third sclk stage keeps edge history
  assign cs_high   = r_r.cs_sync[1];
  assign din_s     = r_r.di_sync[1];
  assign sclk_rise = r_r.ck_sync[1] & ~r_r.ck_sync[2];
  assign sclk_fall = ~r_r.ck_sync[1] & r_r.ck_sync[2];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_nxt         = r_r;
    r_nxt.cs_sync = {r_r.cs_sync[0], link.cs_n};
    r_nxt.ck_sync = {r_r.ck_sync[1:0], link.sclk};
    r_nxt.di_sync = {r_r.di_sync[0], link.din};
    r_nxt.taken   = 1'b0;

    // internal clock conversion runs on aclk, not on sclk
    if (r_r.out_ph == OS_CONV) begin
      if (r_r.conv_cnt == CONV_LAST) begin
        r_nxt.strb   = 1'b1;
        r_nxt.out_ph = OS_MSB;
      end else begin
        r_nxt.conv_cnt = r_r.conv_cnt + `CONV_CNT_W'(1);
      end
    end

    if (cs_high) begin
      r_nxt.in_ph   = PH_HUNT;
      r_nxt.bit_cnt = 4'h0;
      r_nxt.track   = 1'b0;
      r_nxt.out_ph  = OS_IDLE;
      r_nxt.dout    = 1'b0;
    end else if (sclk_rise) begin
      case (r_r.in_ph)
        PH_HUNT: begin
          if (din_s) begin
            r_nxt.ctrl         = 8'h01;
            r_nxt.bit_cnt      = 4'h1;
            r_nxt.in_ph        = PH_CTRL;
            r_nxt.powered_down = 1'b0;
          end
        end
        PH_CTRL: begin
          r_nxt.ctrl    = {r_r.ctrl[6:0], din_s};
          r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          if (r_r.bit_cnt == `CB_BITS - 4'h1) begin
            r_nxt.in_ph = PH_SKIP;
          end
        end
        PH_SKIP: begin
          // din is don't-care until the conversion's last sclk
          r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          if (r_r.bit_cnt == `CONV_SCLKS - 4'h1) begin
            r_nxt.in_ph   = PH_HUNT;
            r_nxt.bit_cnt = 4'h0;
          end
        end
        default: begin
          r_nxt.in_ph = PH_HUNT;
        end
      endcase
    end else if (sclk_fall) begin
      if (r_r.in_ph == PH_CTRL && r_r.bit_cnt == `TRACK_BIT) begin
        r_nxt.track = 1'b1;
      end
      if (r_r.in_ph == PH_SKIP && r_r.bit_cnt == `CB_BITS) begin
        r_nxt.track    = 1'b0;
        r_nxt.taken    = 1'b1;
        r_nxt.res      = sample_data;
        r_nxt.pc       = power_clock_t'(r_r.ctrl[`CB_PC_HI:`CB_PC_LO]);
        r_nxt.unipolar = r_r.ctrl[`CB_POLARITY];
        {r_nxt.pos_ch, r_nxt.neg_ch} = decode_channels(r_r.ctrl);
        case (power_clock_t'(r_r.ctrl[`CB_PC_HI:`CB_PC_LO]))
          PC_EXT_CLK: begin
            r_nxt.strb   = 1'b1;
            r_nxt.out_ph = OS_MSB;
          end
          PC_INT_CLK: begin
            r_nxt.strb     = 1'b0;
            r_nxt.conv_cnt = '0;
            r_nxt.out_ph   = OS_CONV;
          end
          default: begin
            // both power-down codes park the converter, no result
            r_nxt.powered_down = 1'b1;
            r_nxt.out_ph       = OS_IDLE;
          end
        endcase
      end
      case (r_r.out_ph)
        OS_MSB: begin
          if (r_r.pc == PC_EXT_CLK) begin
            r_nxt.strb = 1'b0;
          end
          r_nxt.dout    = r_r.res[`RESULT_BITS-1];
          r_nxt.res     = {r_r.res[`RESULT_BITS-2:0], 1'b0};
          r_nxt.out_cnt = 4'(`RESULT_BITS - 1);
          r_nxt.out_ph  = OS_SHIFT;
        end
        OS_SHIFT: begin
          if (r_r.out_cnt == 4'h0) begin
            r_nxt.dout   = 1'b0;
            r_nxt.out_ph = OS_IDLE;
          end else begin
            r_nxt.dout    = r_r.res[`RESULT_BITS-1];
            r_nxt.res     = {r_r.res[`RESULT_BITS-2:0], 1'b0};
            r_nxt.out_cnt = r_r.out_cnt - 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r         <= '0;
      r_r.cs_sync <= 2'b11;
      r_r.pc      <= PC_EXT_CLK;
      r_r.neg_ch  <= `COM_CODE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // release follows the synchronised select, so it lags the pin by up to 2 aclk
  assign link.dout_o  = r_r.dout;
  assign link.dout_oe = ~cs_high;
  assign link.strb_o  = r_r.strb;
  assign link.strb_oe = ~cs_high | (r_r.pc == PC_INT_CLK);

  assign sample_taken     = r_r.taken;
  assign tracking         = r_r.track;
  assign pos_channel      = r_r.pos_ch;
  assign neg_channel      = r_r.neg_ch;
  assign unipolar         = r_r.unipolar;
  assign power_clock_mode = r_r.pc;
  assign powered_down     = r_r.powered_down;

endmodule : adc_serial_device

// file: core/adc_serial_host.sv
`timescale 1ns/1ns
module adc_serial_host
  import adc_link_pkg::*;
#(
  parameter int SCLK_HALF = `SCLK_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  adc_link_if.host         link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output      logic        irq
);

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  host_state_t r_r;
  host_state_t r_nxt;
  logic        do_write;
  logic [1:0]  ev_set;

  assign s_axi_awready = ~r_r.aw_hold & ~r_r.bvalid;
  assign s_axi_wready  = ~r_r.w_hold & ~r_r.bvalid;
  assign s_axi_arready = ~r_r.rvalid;
  assign do_write      = r_r.aw_hold & r_r.w_hold;

  always_comb begin
    r_nxt         = r_r;
    ev_set        = 2'b00;
    r_nxt.do_sync = {r_r.do_sync[0], link.dout};
    r_nxt.st_sync = {r_r.st_sync[0], link.strb};

    // ****************************************
    // register bus
    // ****************************************
    if (s_axi_awvalid & s_axi_awready) begin
      r_nxt.aw_hold = 1'b1;
      r_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      r_nxt.w_hold  = 1'b1;
      r_nxt.w_data  = s_axi_wdata;
      r_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid & s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (s_axi_rvalid & s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (do_write) begin
      r_nxt.aw_hold = 1'b0;
      r_nxt.w_hold  = 1'b0;
      r_nxt.bvalid  = 1'b1;
      r_nxt.bresp   = 2'b00;
      case (r_r.aw_addr)
        `REG_CTRL: begin
          if (r_r.w_lane0 && r_r.ph != H_IDLE) begin
            ev_set[`EV_REJECT] = 1'b1;
          end else if (r_r.w_lane0) begin
            // one frame per write: byte out, result in
            r_nxt.ctrl_byte = r_r.w_data[7:0];
            r_nxt.ph        = H_RUN;
            r_nxt.cs_n      = 1'b0;
            r_nxt.sclk      = 1'b0;
            r_nxt.din       = r_r.w_data[7];
            r_nxt.tx        = r_r.w_data[7:0];
            r_nxt.div       = 8'h00;
            r_nxt.bit_cnt   = 5'h00;
            r_nxt.saw_low   = 1'b0;
          end
        end
        `REG_STATUS: begin
          if (r_r.w_lane0) begin
            r_nxt.status = r_r.status & ~r_r.w_data[1:0];
          end
        end
        `REG_MASK: begin
          if (r_r.w_lane0) begin
            r_nxt.mask = r_r.w_data[1:0];
          end
        end
        `REG_RESULT: begin
        end
        default: begin
          r_nxt.bresp = 2'b10;
        end
      endcase
    end
    if (s_axi_arvalid & s_axi_arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = 2'b00;
      r_nxt.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `REG_CTRL:   r_nxt.rdata[7:0] = r_r.ctrl_byte;
        `REG_STATUS: r_nxt.rdata[2:0] = {r_r.ph != H_IDLE, r_r.status};
        `REG_MASK:   r_nxt.rdata[1:0] = r_r.mask;
        `REG_RESULT: r_nxt.rdata[`RESULT_BITS-1:0] = r_r.result;
        default:     r_nxt.rresp = 2'b10;
      endcase
    end

    // ****************************************
    // serial frame
    // ****************************************
    case (r_r.ph)
      H_RUN: begin
        r_nxt.div = r_r.div + 8'h01;
        if (r_r.div == HALF_LAST) begin
          r_nxt.div  = 8'h00;
          r_nxt.sclk = ~r_r.sclk;
          if (!r_r.sclk) begin
            r_nxt.rx      = {r_r.rx[22:0], r_r.do_sync[1]};
            r_nxt.bit_cnt = r_r.bit_cnt + 5'h01;
          end else begin
            // zeros follow the control byte
            r_nxt.tx  = {r_r.tx[6:0], 1'b0};
            r_nxt.din = r_r.tx[6];
            if (r_r.bit_cnt == `FRAME_SCLKS) begin
              r_nxt.ph = H_TAIL;
            end else if (r_r.bit_cnt == 5'(`CB_BITS) &&
                         r_r.ctrl_byte[1:0] == PC_INT_CLK) begin
              r_nxt.ph = H_WAIT;
            end
          end
        end
      end
      H_WAIT: begin
        // strobe must be seen low first, else a stale high ends the wait
        if (!r_r.st_sync[1]) begin
          r_nxt.saw_low = 1'b1;
        end else if (r_r.saw_low) begin
          r_nxt.ph = H_RUN;
        end
      end
      H_TAIL: begin
        r_nxt.div = r_r.div + 8'h01;
        if (r_r.div == HALF_LAST) begin
          r_nxt.cs_n   = 1'b1;
          r_nxt.ph     = H_IDLE;
          r_nxt.result = r_r.rx[`RES_MSB_POS:`RES_LSB_POS];
          ev_set[`EV_DONE] = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // set beats a same-cycle clear
    r_nxt.status = r_nxt.status | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r      <= '0;
      r_r.cs_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp  = r_r.bresp;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata  = r_r.rdata;
  assign s_axi_rresp  = r_r.rresp;
  assign irq          = |(r_r.status & r_r.mask);
  assign link.sclk    = r_r.sclk;
  assign link.cs_n    = r_r.cs_n;
  assign link.din     = r_r.din;

endmodule : adc_serial_host

// file: verification/adc_serial_control_byte_port_sva.sv
`timescale 1ns/1ns
module adc_serial_control_byte_port_sva #(
  parameter int SCLK_HALF = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic strb_o,
  input wire logic strb_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****************************************
  // helper counters
  // ****************************************
  logic [4:0] rise_cnt_r;
  logic [7:0] hi_cnt_r;
  logic       sclk_d_r;
  logic       ext_r;

  // a strobe rising soon after an sclk fall belongs to external mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_cnt_r <= 5'h00;
      hi_cnt_r   <= 8'h00;
      sclk_d_r   <= 1'b0;
      ext_r      <= 1'b0;
    end else begin
      sclk_d_r   <= sclk;
      rise_cnt_r <= cs_n ? 5'h00 : rise_cnt_r + 5'((sclk && !sclk_d_r) ? 1 : 0);
      hi_cnt_r   <= strb_o ? hi_cnt_r + 8'h01 : 8'h00;
      ext_r      <= $rose(strb_o) ? $past(sclk, 6) : ext_r;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  property p_dout_on_fall;
    $changed(dout_o) && dout_oe && $past(dout_oe) |-> !sclk && $past(sclk, 6);
  endproperty
  property p_strb_on_fall;
    $changed(strb_o) && strb_oe && $past(strb_oe) |-> !sclk;
  endproperty
  property p_ext_strobe;
    $fell(strb_o) && ext_r |-> hi_cnt_r == 8'(2 * SCLK_HALF);
  endproperty
  property p_release;
    cs_n [*6] |-> !dout_oe;
  endproperty
  property p_oe_select;
    $rose(dout_oe) |-> !cs_n;
  endproperty
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  property p_din_on_fall;
    !cs_n && $changed(din) |-> !sclk;
  endproperty
  property p_frame_len;
    $rose(cs_n) |-> rise_cnt_r == 5'h18;
  endproperty

  a_dout_on_fall: assert property (p_dout_on_fall) else $error("dout moved off a fall");
  a_strb_on_fall: assert property (p_strb_on_fall) else $error("strobe moved off a fall");
  a_ext_strobe: assert property (p_ext_strobe) else $error("strobe width wrong");
  a_release: assert property (p_release) else $error("dout driven while deselected");
  a_oe_select: assert property (p_oe_select) else $error("dout enabled while deselected");
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high outside frame");
  a_din_on_fall: assert property (p_din_on_fall) else $error("din moved with sclk high");
  a_frame_len: assert property (p_frame_len) else $error("frame clock count wrong");

  c_ext_strobe: cover property ($rose(strb_o) && $past(sclk, 6));
  c_int_strobe: cover property ($rose(strb_o) && !$past(sclk, 6));
  c_frame_end: cover property ($rose(cs_n));
endmodule : adc_serial_control_byte_port_sva

// file: verification/adc_serial_control_byte_port_test.sv
`timescale 1ns/1ns
`include "adc_link_params.svh"
module adc_serial_control_byte_port_test;
  import adc_link_pkg::*;
  localparam int HALF  = 6;
  localparam int LIMIT = 30000;
  logic        aclk, aresetn, irq;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, power_clock_mode;
  logic [9:0]  sample_data;
  logic        sample_taken, tracking, unipolar, powered_down;
  logic [2:0]  pos_channel;
  logic [3:0]  neg_channel;
  int          error_cnt, n_checks, cyc, takes, trk;

  adc_link_if adc_link_if_i ();
  adc_serial_host #(.SCLK_HALF(HALF)) adc_serial_host_i (
    .aclk, .aresetn, .link(adc_link_if_i), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  adc_serial_device #(.CONV_CYCLES_INT(8)) adc_serial_device_i (
    .aclk, .aresetn, .link(adc_link_if_i), .sample_data, .sample_taken, .tracking,
    .pos_channel, .neg_channel, .unipolar, .power_clock_mode, .powered_down);
  adc_serial_control_byte_port_sva #(.SCLK_HALF(HALF)) adc_serial_control_byte_port_sva_i (
    .aclk, .aresetn, .sclk(adc_link_if_i.sclk), .cs_n(adc_link_if_i.cs_n),
    .din(adc_link_if_i.din), .dout_o(adc_link_if_i.dout_o), .dout_oe(adc_link_if_i.dout_oe),
    .strb_o(adc_link_if_i.strb_o), .strb_oe(adc_link_if_i.strb_oe));

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ready is registered, so a look at the falling edge predicts the next rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rck(input string what, input logic [3:0] a, input logic [31:0] exp);
    rd(a, d, r);
    check(what, d, exp);
  endtask : rck

  task automatic irq_is(input logic exp);
    @(negedge aclk);
    check("irq", 32'(irq), 32'(exp));
  endtask : irq_is

  task automatic wait_irq;
    int n;
    n = 0;
    @(negedge aclk);
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge aclk);
      n++;
    end
    if (irq !== 1'b1) check("irq wait", 32'(irq), 32'h1);
  endtask : wait_irq

  // eb is the byte the device should assemble once leading zeros are skipped
  task automatic frame(input logic [7:0] cb, input logic [7:0] eb, input logic [9:0] smp);
    int t0;
    int k0;
    @(negedge aclk);
    t0 = takes;
    k0 = trk;
    @(posedge aclk);
    sample_data <= smp;
    wr(`REG_CTRL, 32'(cb), r);
    wait_irq;
    check("pos", 32'(pos_channel), 32'({eb[5], eb[4], eb[6]}));
    check("neg", 32'(neg_channel), eb[2] ? 32'h8 : 32'({eb[5], eb[4], ~eb[6]}));
    check("unipolar", 32'(unipolar), 32'(eb[3]));
    check("mode", 32'(power_clock_mode), 32'(eb[1:0]));
    check("pwrdn", 32'(powered_down), 32'(!eb[1]));
    check("samples", 32'(takes - t0), 32'h1);
    check("track", 32'(trk - k0), 32'(6 * HALF));
    if (eb[1]) rck("result", `REG_RESULT, 32'(smp));
    rck("status", `REG_STATUS, 32'h1);
    wr(`REG_STATUS, 32'h1, r);
    irq_is(1'b0);
  endtask : frame

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sample_taken === 1'b1) takes++;
    if (tracking === 1'b1) trk++;
    if (cyc == LIMIT) begin
      error_cnt++;
      close_out;
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_data} = 50'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rck("status0", `REG_STATUS, 32'h0);
    rck("mask0", `REG_MASK, 32'h0);
    wr(`REG_MASK, 32'h1, r);
    frame(8'h0F, 8'hF0, 10'h155);
    frame(8'hF5, 8'hF5, 10'h0AA);
    frame(8'hFF, 8'hFF, 10'h3C1);
    wr(`REG_RESULT, 32'h0, r);
    rck("ro result", `REG_RESULT, 32'h3C1);
    frame(8'hFE, 8'hFE, 10'h2D4);
    for (int i = 0; i < 16; i++) begin
      frame(8'({1'b1, i[2:0], i[0], ~i[3], 2'b11}), 8'({1'b1, i[2:0], i[0], ~i[3], 2'b11}),
            10'(i * 73 + 5));
    end
    wr(`REG_CTRL, 32'hFF, r);
    wr(`REG_CTRL, 32'h8F, r);
    wait_irq;
    rck("reject", `REG_STATUS, 32'h3);
    check("busy byte kept", 32'(pos_channel), 32'h7);
    wr(`REG_MASK, 32'h0, r);
    irq_is(1'b0);
    wr(`REG_MASK, 32'h2, r);
    irq_is(1'b1);
    wr(`REG_STATUS, 32'h3, r);
    irq_is(1'b0);
    wr(4'h2, 32'h1, r);
    check("bresp", 32'(r), 32'h2);
    rd(4'h6, d, r);
    check("rresp", 32'(r), 32'h2);
    close_out;
  end
endmodule : adc_serial_control_byte_port_test
